// File: rtl/pba_consts.svh
// Register map, field positions and reset values of the bus adapter.
// Included by the adapter top; holds definitions only.
`ifndef PBA_CONSTS_SVH
`define PBA_CONSTS_SVH

// Register indices; byte address is four times the index
`define PBA_IDX_CTL      18'h09000
`define PBA_IDX_VEC      18'h09002
`define PBA_IDX_STAT     18'h09004
`define PBA_IDX_RDDAT    18'h09006
`define PBA_IDX_PADDR    18'h09008
`define PBA_IDX_PWRITE   18'h0900A
`define PBA_IDX_PREAD    18'h0900C
`define PBA_IDX_ISTAT    18'h0900E
`define PBA_IDX_IMASK    18'h09010
`define PBA_IDX_SADDR    18'h09012

// Control field positions
`define PBA_CTL_BYTE     0
`define PBA_CTL_BRM_LO   1
`define PBA_CTL_BRM_HI   4
`define PBA_CTL_NPRM     5
`define PBA_CTL_IRQEN    6
`define PBA_CTL_NINIT    7
`define PBA_CTL_NTEST    11
`define PBA_CTL_RESET    16'h00BE
`define PBA_CTL_ENABLE   16'h3FC0

// Status field positions
`define PBA_ST_DONE      10
`define PBA_ST_IPEND     7

// Interrupt status bits
`define PBA_IS_DONE      0
`define PBA_IS_PINT      1
`define PBA_IS_ATTN      2

// Host command codes (values arbitrary, set at integration)
`define PBA_CMD_SETADDR  8'h21
`define PBA_CMD_SENSE    8'h04

`define PBA_RESP_OKAY    2'h0
`define PBA_RESP_SLVERR  2'h2

`endif

// File: rtl/pba_pkg.sv
// Types shared by the bus adapter and its bench.
// Assumes pba_consts.svh for field values.
package pba_pkg;

    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pba_cycle_t;

    typedef struct packed {
        logic chan_end;
        logic dev_end;
        logic attention;
    } pba_host_stat_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CYCLE,
        ST_RELEASE
    } pba_state_t;

endpackage

// File: rtl/pba_adapter.sv
// Parallel bus adapter: control, status, interrupt vector, register cycles
// and host start-address / sense command handling.
// Assumes one clock; peripheral inputs are asynchronous and synchronised.
//
// How it works
// - Set-address command loads four-byte start address
// - Start address held until next set-address
// - Report channel/device end; attention on peripheral activity
// - Sense command returns held sense byte
// - Control register is sixteen bits, write-only
// - Status register read-only, shows adapter state
// - Bit 15 most significant, bit 0 least
// - Pending interrupt blocks other bus operations
// - Vector read returns vector, clears interrupt
// - Control mask bits suppress levels four-seven
// - Software requests peripheral register reads/writes
// - Enable value allows interrupts, non-processor, bus requests
// - Enable value releases bus reset, self-test
// - Reset leaves interrupts off, levels masked
// - Done bit sets on finish, data read clears
// - Control bit 7 zero drives initialize line
// - Control bits 1-4 mask request levels
// - Control bit 0 selects byte transfers
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "pba_consts.svh"

module pba_adapter (
    input  wire logic                    clk,
    input  wire logic                    rst,
    // AXI4-Lite slave
    input  wire logic [19:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [19:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic                         irq,
    // Host channel command port
    input  wire logic                    host_cmd_valid,
    input  wire logic [7:0]              host_cmd_code,
    input  wire logic [31:0]             host_cmd_data,
    output logic                         host_resp_valid,
    output pba_pkg::pba_host_stat_t      host_stat,
    output logic [7:0]                   host_sense,
    output logic [31:0]                  xfer_start_addr,
    // Parallel bus side
    output pba_pkg::pba_cycle_t          pb_cycle,
    output logic                         pb_req,
    input  wire logic                    pb_ack,
    input  wire logic [15:0]             pb_rdata,
    input  wire logic                    interrupt_request_line,
    input  wire logic [15:0]             pb_vector,
    output logic                         pb_int_clear,
    input  wire logic [3:0]              bus_request_level,
    output logic [3:0]                   bus_request_pass,
    input  wire logic                    non_processor_request,
    output logic                         non_processor_grant,
    output logic                         pb_init,
    output logic                         pb_self_test,
    output logic                         pb_byte_xfer,
    output logic [2:0]                   pb_mode
);
    import pba_pkg::*;

    function automatic logic [17:0] reg_index(input logic [19:0] a);
        reg_index = a[19:2];
    endfunction

    // Synchronisers for asynchronous bus inputs
    logic [38:0] sync1_q;
    logic [38:0] sync2_q;
    logic        ack_s;
    logic        ireq_s;
    logic        nreq_s;
    logic [3:0]  br_s;
    logic [15:0] rdat_s;
    logic [15:0] pvec_s;

    // Data words ride with their strobes so both arrive on the same edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 39'h00;
            sync2_q <= 39'h00;
        end else begin
            sync1_q <= {pb_ack, interrupt_request_line,
                        non_processor_request, bus_request_level,
                        pb_rdata, pb_vector};
            sync2_q <= sync1_q;
        end
    end
    assign {ack_s, ireq_s, nreq_s, br_s, rdat_s, pvec_s} = sync2_q;

    // AXI write channel: address and data are taken together
    logic        wr_fire;
    logic [17:0] wr_idx;
    logic        wr_hit;

    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_fire       = s_axi_awready;
    assign wr_idx        = reg_index(s_axi_awaddr);
    assign wr_hit = (wr_idx == `PBA_IDX_CTL)   || (wr_idx == `PBA_IDX_PADDR)
                 || (wr_idx == `PBA_IDX_PWRITE) || (wr_idx == `PBA_IDX_PREAD)
                 || (wr_idx == `PBA_IDX_ISTAT)  || (wr_idx == `PBA_IDX_IMASK);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PBA_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PBA_RESP_OKAY : `PBA_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic we_ctl;
    logic we_paddr;
    logic we_pwrite;
    logic we_pread;
    logic we_istat;
    logic we_imask;
    logic lo_en;
    logic hi_en;

    assign lo_en     = s_axi_wstrb[0];
    assign hi_en     = s_axi_wstrb[1];
    assign we_ctl    = wr_fire && wr_idx == `PBA_IDX_CTL;
    assign we_paddr  = wr_fire && wr_idx == `PBA_IDX_PADDR;
    assign we_pwrite = wr_fire && wr_idx == `PBA_IDX_PWRITE;
    assign we_pread  = wr_fire && wr_idx == `PBA_IDX_PREAD;
    assign we_istat  = wr_fire && wr_idx == `PBA_IDX_ISTAT && lo_en;
    assign we_imask  = wr_fire && wr_idx == `PBA_IDX_IMASK && lo_en;

    // Control register, 16 bits, bit 15 MSB
    logic [15:0] ctl_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q <= `PBA_CTL_RESET;
        end else if (we_ctl) begin
            if (lo_en) begin
                ctl_q[7:0] <= s_axi_wdata[7:0];
            end
            if (hi_en) begin
                ctl_q[15:8] <= s_axi_wdata[15:8];
            end
        end
    end

    logic [3:0] br_mask;
    assign br_mask          = ctl_q[`PBA_CTL_BRM_HI:`PBA_CTL_BRM_LO];
    assign pb_init          = !ctl_q[`PBA_CTL_NINIT];
    assign pb_self_test     = !ctl_q[`PBA_CTL_NTEST];
    assign pb_byte_xfer     = ctl_q[`PBA_CTL_BYTE];
    assign pb_mode          = ctl_q[10:8];
    assign bus_request_pass = br_s & ~br_mask;

    // Interrupt from the parallel bus
    logic        qual_now;
    logic        qual_q;
    logic        int_pend_q;
    logic [15:0] vec_q;
    logic        int_clear_q;
    logic        rd_vec;

    assign qual_now = ireq_s && (|bus_request_pass) && !pb_init;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qual_q     <= 1'b0;
            int_pend_q <= 1'b0;
            vec_q      <= 16'h0000;
        end else begin
            qual_q <= qual_now;
            if (qual_now && !qual_q) begin
                int_pend_q <= 1'b1;
                vec_q      <= pvec_s;
            end else if (rd_vec || pb_init) begin
                int_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_clear_q <= 1'b0;
        end else if (rd_vec && int_pend_q) begin
            int_clear_q <= 1'b1;
        end else if (!ireq_s) begin
            int_clear_q <= 1'b0;
        end
    end
    assign pb_int_clear = int_clear_q;

    assign non_processor_grant = nreq_s && !ctl_q[`PBA_CTL_NPRM]
                              && !int_pend_q && !pb_init;

    // Peripheral register cycle engine
    pba_state_t  state_q;
    logic [17:0] paddr_q;
    logic [15:0] pwdata_q;
    logic        op_wr_q;
    logic        op_want_q;
    logic [15:0] rddat_q;
    logic        done_q;
    logic        done_set;
    logic        rd_rddat;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            paddr_q  <= 18'h00000;
            pwdata_q <= 16'h0000;
            op_wr_q  <= 1'b0;
        end else begin
            if (we_paddr) begin
                paddr_q <= s_axi_wdata[17:0];
            end
            if (we_pwrite) begin
                pwdata_q <= s_axi_wdata[15:0];
                op_wr_q  <= 1'b1;
            end else if (we_pread) begin
                op_wr_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_want_q <= 1'b0;
        end else if (we_pwrite || we_pread) begin
            op_want_q <= 1'b1;
        end else if (state_q == ST_IDLE && !int_pend_q && !pb_init) begin
            op_want_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (op_want_q && !int_pend_q && !pb_init) begin
                        state_q <= ST_CYCLE;
                    end
                end
                ST_CYCLE: begin
                    if (ack_s) begin
                        state_q <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!ack_s) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign pb_req         = state_q == ST_CYCLE;
    assign pb_cycle.addr  = paddr_q;
    assign pb_cycle.wdata = pwdata_q;
    assign pb_cycle.wr    = op_wr_q;
    assign pb_cycle.rd    = !op_wr_q;
    assign done_set       = state_q == ST_CYCLE && ack_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rddat_q <= 16'h0000;
        end else if (done_set && !op_wr_q) begin
            rddat_q <= rdat_s;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (rd_rddat) begin
            done_q <= 1'b0;
        end
    end

    // Host channel commands
    logic [31:0] saddr_q;
    logic        attn_q;
    logic        resp_q;
    logic [7:0]  sense_q;
    logic        is_sense;

    assign is_sense = host_cmd_valid && host_cmd_code == `PBA_CMD_SENSE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            saddr_q <= 32'h00000000;
        end else if (host_cmd_valid
                     && host_cmd_code == `PBA_CMD_SETADDR) begin
            saddr_q <= host_cmd_data;
        end
    end
    assign xfer_start_addr = saddr_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            attn_q <= 1'b0;
        end else if (qual_now && !qual_q) begin
            attn_q <= 1'b1;
        end else if (is_sense) begin
            attn_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_q     <= 1'b0;
            sense_q    <= 8'h00;
            host_sense <= 8'h00;
        end else begin
            resp_q  <= host_cmd_valid;
            sense_q <= {4'h0, pb_init, int_pend_q, done_q, attn_q};
            if (is_sense) begin
                host_sense <= sense_q;
            end
        end
    end
    assign host_resp_valid     = resp_q;
    assign host_stat.chan_end  = resp_q;
    assign host_stat.dev_end   = resp_q;
    assign host_stat.attention = attn_q;

    // Local interrupt status and mask
    logic [2:0] istat_q;
    logic [2:0] imask_q;
    logic [2:0] ev;

    assign ev = {qual_now && !qual_q && !attn_q,
                 qual_now && !qual_q && ctl_q[`PBA_CTL_IRQEN],
                 done_set};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            istat_q <= 3'h0;
            imask_q <= 3'h0;
        end else begin
            istat_q <= ev | (istat_q & ~(we_istat ? s_axi_wdata[2:0] : 3'h0));
            if (we_imask) begin
                imask_q <= s_axi_wdata[2:0];
            end
        end
    end
    assign irq = |(istat_q & imask_q);

    // AXI read channel
    logic [17:0] rd_idx;
    logic        rd_fire;
    logic [15:0] stat_word;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_idx        = reg_index(s_axi_araddr);
    assign rd_vec        = rd_fire && rd_idx == `PBA_IDX_VEC;
    assign rd_rddat      = rd_fire && rd_idx == `PBA_IDX_RDDAT;
    assign stat_word     = {5'h00, done_q, 2'h0, int_pend_q,
                            ctl_q[6:0]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PBA_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PBA_RESP_OKAY;
            unique case (rd_idx)
                `PBA_IDX_CTL:   s_axi_rdata <= 32'h00000000;
                `PBA_IDX_VEC:   s_axi_rdata <= {16'h0000, vec_q};
                `PBA_IDX_STAT:  s_axi_rdata <= {16'h0000, stat_word};
                `PBA_IDX_RDDAT: s_axi_rdata <= {16'h0000, rddat_q};
                `PBA_IDX_ISTAT: s_axi_rdata <= {29'h0, istat_q};
                `PBA_IDX_IMASK: s_axi_rdata <= {29'h0, imask_q};
                `PBA_IDX_SADDR: s_axi_rdata <= saddr_q;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PBA_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    blocked_op_a: assert property (@(posedge clk) disable iff (rst)
        int_pend_q && state_q == ST_IDLE |=> state_q == ST_IDLE)
        else $error("bus cycle began while interrupt pending");

    vec_clear_a: assert property (@(posedge clk) disable iff (rst)
        rd_vec && int_pend_q && !(qual_now && !qual_q)
        |=> !int_pend_q && pb_int_clear)
        else $error("vector read did not clear interrupt");

    done_set_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_CYCLE && ack_s |=> done_q && state_q == ST_RELEASE)
        else $error("done flag not set on completion");

    done_clr_a: assert property (@(posedge clk) disable iff (rst)
        rd_rddat && !done_set |=> !done_q)
        else $error("data read did not clear done");

    init_line_a: assert property (@(posedge clk) disable iff (rst)
        we_ctl && lo_en |=> pb_init == !$past(s_axi_wdata[7]))
        else $error("initialize line wrong after control write");

    br_mask_a: assert property (@(posedge clk) disable iff (rst)
        ((bus_request_pass & ctl_q[4:1]) == 4'h0))
        else $error("masked request level passed");

    enable_val_a: assert property (@(posedge clk) disable iff (rst)
        we_ctl && lo_en && hi_en && s_axi_wdata[15:0] == `PBA_CTL_ENABLE
        |=> !pb_init && !pb_self_test && ctl_q[6] && br_mask == 4'h0)
        else $error("enable value did not open interface");

    saddr_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(host_cmd_valid && host_cmd_code == `PBA_CMD_SETADDR)
        |=> $stable(xfer_start_addr))
        else $error("start address changed without command");

    resp_ce_a: assert property (@(posedge clk) disable iff (rst)
        host_cmd_valid |=> host_resp_valid && host_stat.chan_end
                           && host_stat.dev_end)
        else $error("command not ended with channel/device end");

    sense_a: assert property (@(posedge clk) disable iff (rst)
        is_sense && !(qual_now && !qual_q)
        |=> host_sense == $past(sense_q) && !attn_q)
        else $error("sense did not return held sense");

    byte_mode_a: assert property (@(posedge clk) disable iff (rst)
        we_ctl && lo_en |=> pb_byte_xfer == $past(s_axi_wdata[0]))
        else $error("byte transfer select wrong");

endmodule // pba_adapter

// File: bench/pba_periph_model.sv
// Far-side model: register slave, interrupter, non-processor requester.
// Assumes the adapter's clock and stimulus from the bench.
`timescale 1ns/1ns

module pba_periph_model (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire pba_pkg::pba_cycle_t pb_cycle,
    input  wire logic                pb_req,
    output logic                     pb_ack,
    output logic [15:0]              pb_rdata,
    output logic                     interrupt_request_line,
    output logic [15:0]              pb_vector,
    input  wire logic                pb_int_clear,
    output logic [3:0]               bus_request_level,
    output logic                     non_processor_request,
    input  wire logic [3:0]          ack_dly,
    input  wire logic                int_go,
    input  wire logic [3:0]          int_lvl,
    input  wire logic [15:0]         int_vec,
    input  wire logic                nreq_go
);
    import pba_pkg::*;
    logic [15:0] mem_q [8];
    logic [3:0]  cnt_q;
    logic        clr_q;
    // Answers ack_dly+1 cycles after the request; released data toggles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pb_ack <= 1'b0;
            cnt_q <= 4'h0;
            pb_rdata <= 16'h0000;
        end else if (!pb_req) begin
            pb_ack <= 1'b0;
            cnt_q <= 4'h0;
            pb_rdata <= ~pb_rdata;
        end else if (cnt_q < ack_dly) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (!pb_ack) begin
            pb_ack <= 1'b1;
            pb_rdata <= mem_q[pb_cycle.addr[3:1]];
            if (pb_cycle.wr) mem_q[pb_cycle.addr[3:1]] <= pb_cycle.wdata;
        end
    end
    // Request stays up while int_go is high until the adapter clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interrupt_request_line <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            interrupt_request_line <= int_go & ~clr_q & ~pb_int_clear;
            clr_q <= int_go & (clr_q | pb_int_clear);
        end
    end
    assign bus_request_level = interrupt_request_line ? int_lvl : 4'h0;
    assign pb_vector = interrupt_request_line ? int_vec : ~int_vec;
    assign non_processor_request = nreq_go;
endmodule // pba_periph_model

// File: bench/pba_adapter_bench.sv
// Self-checking bench: AXI4-Lite master, host commands, far-side model.
// Assumes the adapter top, its package and register constants.
`timescale 1ns/1ns
`include "pba_consts.svh"

module pba_adapter_bench;
    import pba_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic [19:0]    awaddr = '0;
    logic [19:0]    araddr = '0;
    logic [31:0]    wdata = '0;
    logic           awvalid = 0, wvalid = 0, bready = 0;
    logic           arvalid = 0, rready = 0, cmd_v = 0, igo = 0, ngo = 0;
    logic           awready, wready, bvalid, arready, rvalid, irq, resp_v;
    logic [1:0]     bresp, rresp, r;
    logic [31:0]    rdata, sadr;
    logic [7:0]     cmd_c = '0;
    logic [31:0]    cmd_d = '0;
    pba_host_stat_t hst;
    logic [7:0]     sense;
    pba_cycle_t     cyc;
    logic           req, ack, ireq, iclr, nreq, grant, init, stest, bytex;
    logic           saw_clr = 0;
    logic [15:0]    prd, vec, q;
    logic [3:0]     brl, brp;
    logic [2:0]     mode;
    logic [3:0]     dly = '0, lvl = '0;
    int             miscompares = 0, n_checks = 0, cyc_n = 0;

    pba_adapter i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .host_cmd_valid(cmd_v), .host_cmd_code(cmd_c), .host_cmd_data(cmd_d),
        .host_resp_valid(resp_v), .host_stat(hst), .host_sense(sense),
        .xfer_start_addr(sadr), .pb_cycle(cyc), .pb_req(req), .pb_ack(ack),
        .pb_rdata(prd), .interrupt_request_line(ireq), .pb_vector(vec),
        .pb_int_clear(iclr), .bus_request_level(brl),
        .bus_request_pass(brp), .non_processor_request(nreq),
        .non_processor_grant(grant), .pb_init(init), .pb_self_test(stest),
        .pb_byte_xfer(bytex), .pb_mode(mode));

    pba_periph_model i_model (.clk(clk), .rst(rst), .pb_cycle(cyc),
        .pb_req(req), .pb_ack(ack), .pb_rdata(prd),
        .interrupt_request_line(ireq), .pb_vector(vec), .pb_int_clear(iclr),
        .bus_request_level(brl), .non_processor_request(nreq), .ack_dly(dly),
        .int_go(igo), .int_lvl(lvl), .int_vec(16'h0154), .nreq_go(ngo));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (iclr === 1'b1) saw_clr <= 1'b1;
        cyc_n++;
        if (cyc_n == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [17:0] idx, input logic [15:0] d);
        logic a, w;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            a = awvalid && awready;
            w = wvalid && wready;
            @(posedge clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while ((awvalid && !a) || (wvalid && !w));
        do begin
            @(negedge clk);
            r = bresp;
        end while (bvalid !== 1'b1);
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] idx, output logic [15:0] d);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do begin
            @(negedge clk);
            d = rdata[15:0];
            r = rresp;
        end while (rvalid !== 1'b1);
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic chkrd(input string nm, input logic [17:0] i, logic [15:0] e);
        rd(i, q);
        chk(nm, q, e);
    endtask

    task automatic poll(input int b);
        do rd(`PBA_IDX_STAT, q); while (q[b] !== 1'b1);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        @(posedge clk);
        cmd_v <= 1'b1;
        cmd_c <= c;
        cmd_d <= d;
        @(posedge clk);
        cmd_v <= 1'b0;
        @(negedge clk);
        chk("resp", {resp_v, hst.chan_end, hst.dev_end}, 3'b111);
        @(negedge clk);
        chk("pulse", resp_v, 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chkrd("stat", `PBA_IDX_STAT, 16'h003E);
        chk("outs", {init, stest, irq, brp}, 7'b010_0000);
        chkrd("ctl", `PBA_IDX_CTL, 16'h0000);
        rd(18'h00040, q);
        chk("unmapped", r, `PBA_RESP_SLVERR);
        wr(`PBA_IDX_STAT, 16'hFFFF);
        chk("ro resp", r, `PBA_RESP_SLVERR);
        chkrd("stat ro", `PBA_IDX_STAT, 16'h003E);
        wr(`PBA_IDX_CTL, 16'h3F40);
        chk("ctl resp", r, `PBA_RESP_OKAY);
        tick(2);
        chk("init", init, 1'b1);
        wr(`PBA_IDX_CTL, 16'h3FC1);
        tick(2);
        chk("ctl out", {init, stest, mode, bytex}, 6'b001111);
        chkrd("stat en", `PBA_IDX_STAT, 16'h0041);
        ngo <= 1'b1;
        tick(5);
        chk("grant", grant, 1'b1);
        wr(`PBA_IDX_CTL, 16'h3FE0);
        tick(5);
        chk("grant off", grant, 1'b0);
        wr(`PBA_IDX_CTL, 16'h3FC0);
        ngo <= 1'b0;
        wr(`PBA_IDX_PADDR, 16'h0004);
        wr(`PBA_IDX_PWRITE, 16'hA5C3);
        poll(`PBA_ST_DONE);
        chkrd("istat", `PBA_IDX_ISTAT, 16'h0001);
        chk("irq masked", irq, 1'b0);
        wr(`PBA_IDX_IMASK, 16'h0001);
        tick(2);
        chk("irq", irq, 1'b1);
        wr(`PBA_IDX_ISTAT, 16'h0001);
        tick(2);
        chk("irq clr", irq, 1'b0);
        rd(`PBA_IDX_RDDAT, q);
        chkrd("done clr", `PBA_IDX_STAT, 16'h0040);
        dly <= 4'h6;
        wr(`PBA_IDX_PREAD, 16'h0000);
        poll(`PBA_ST_DONE);
        chkrd("rddat", `PBA_IDX_RDDAT, 16'hA5C3);
        wr(`PBA_IDX_CTL, 16'h3FDE);
        lvl <= 4'b0010;
        igo <= 1'b1;
        tick(8);
        chk("br masked", brp, 4'h0);
        chkrd("no pend", `PBA_IDX_STAT, 16'h005E);
        igo <= 1'b0;
        tick(4);
        wr(`PBA_IDX_CTL, 16'h3FC0);
        igo <= 1'b1;
        poll(`PBA_ST_IPEND);
        chk("br pass", {brp, hst.attention}, 5'b00101);
        wr(`PBA_IDX_PREAD, 16'h0000);
        tick(12);
        chk("held off", {req, saw_clr}, 2'b00);
        cmd(`PBA_CMD_SENSE, 32'h0);
        chk("sense", {sense, hst.attention}, 9'h00A);
        rd(`PBA_IDX_VEC, q);
        tick(1);
        chk("vector", {q, saw_clr}, {16'h0154, 1'b1});
        poll(`PBA_ST_DONE);
        chkrd("after int", `PBA_IDX_RDDAT, 16'hA5C3);
        cmd(`PBA_CMD_SETADDR, 32'h1234_5678);
        chk("start", sadr, 32'h1234_5678);
        cmd(`PBA_CMD_SENSE, 32'h0);
        chk("held", sadr, 32'h1234_5678);
        cmd(`PBA_CMD_SETADDR, 32'hFEDC_BA98);
        chk("reload", sadr, 32'hFEDC_BA98);
        chkrd("saddr", `PBA_IDX_SADDR, 16'hBA98);
        end_sim();
    end
endmodule // pba_adapter_bench
